//--- design/dpb_pkg.sv
// package: constants, states and carriers of the ddr psram bus block
package dpb_pkg;

    // ************************************************
    // command/address layout
    // ************************************************
    localparam int CA_W = 48;
    localparam logic [2:0] CA_LAST = 3'h5;
    localparam int CA_DIR = 47;
    localparam int CA_SPACE = 46;
    localparam int CA_BURST = 45;
    localparam int CA_DIE = 35;
    localparam int CA_RCFG = 24;
    localparam int CA_RIDX = 0;
    localparam int CA_ROW_LO = 16;

    // ************************************************
    // array and buffer shape
    // ************************************************
    localparam int MEM_AW = 9;
    localparam int MEM_DEPTH = 512;
    localparam int OFF_W = MEM_AW - 1;
    localparam int LCOL_W = 3;
    localparam int UCOL_W = MEM_AW - LCOL_W;
    localparam int BUF_DEPTH = 2;
    localparam int DIES = 2;
    localparam logic DUAL_DIE = 1'b1;
    localparam logic [OFF_W-1:0] OFF_ONE = 8'h01;
    localparam logic [OFF_W-1:0] WRAP_MIN = 8'h08;

    // ************************************************
    // configuration fields and reset values
    // ************************************************
    localparam int CFG_LAT_HI = 7;
    localparam int CFG_LAT_LO = 4;
    localparam int CFG_FIXED = 3;
    localparam int CFG_HYB = 2;
    localparam int CFG_BL_HI = 1;
    localparam int CFG_BL_LO = 0;
    localparam logic [15:0] CFG0_RESET = 16'h0043;
    localparam logic [15:0] CFG1_RESET = 16'h0000;
    localparam logic [4:0] LAT_NONE = 5'h00;
    localparam logic [4:0] LAT_STEP = 5'h01;
    localparam logic [2:0] BYTE_STEP = 3'h1;

    // ************************************************
    // identification contents
    // ************************************************
    localparam logic [3:0] MFR_CODE = 4'h5;    // arbitrary value
    localparam logic [3:0] DEV_TYPE = 4'hA;    // arbitrary value
    localparam logic [4:0] ID_ROW_CNT = 5'h02;
    localparam logic [3:0] ID_COL_CNT = 4'h5;
    localparam logic [11:0] ID1_PAD = 12'h000;

    // ************************************************
    // states and carriers
    // ************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CA = 2'h1,
        ST_LAT = 2'h3,
        ST_DATA = 2'h2
    } dpb_state_e;

    typedef struct packed {
        logic cs_n;
        logic ck;
        logic read_write_strobe;
        logic [7:0] dq;
    } dpb_pins_s;

    localparam dpb_pins_s PINS_IDLE = 11'h400;

    typedef struct packed {
        logic [MEM_AW-1:0] addr;
        logic [15:0] data;
        logic [1:0] be;
    } dpb_wr_req_s;

endpackage

//--- design/dpb_buf.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
module dpb_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = DEPTH[PW:0];
    localparam logic [PW:0] EMPTY = '0;
    localparam logic [PW-1:0] PSTEP = 1'b1;
    localparam logic [PW:0] CSTEP = {{PW{1'b0}}, 1'b1};

    logic [WIDTH-1:0] slot_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = cnt_q != FULL;
    assign out_valid = cnt_q != EMPTY;
    assign out_data = slot_q[rp_q];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= EMPTY;
        end else if (ce) begin
            if (push) wp_q <= wp_q + PSTEP;
            if (pop) rp_q <= rp_q + PSTEP;
            if (push && !pop) cnt_q <= cnt_q + CSTEP;
            if (pop && !push) cnt_q <= cnt_q - CSTEP;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) slot_q[wp_q] <= in_data;
    end
endmodule // dpb_buf

//--- design/dpb_mem.sv
// single-port word array with byte enables and registered read data
`timescale 1ns/1ps
module dpb_mem #(
    parameter int AW = 9,
    parameter int DEPTH = 512
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] be,
    output logic [15:0] rdata_q
);
    // one array per byte lane, so each lane has a single writing process
    for (genvar b = 0; b < 2; b++) begin : g_lane
        logic [7:0] lane_ram [DEPTH];
        logic [7:0] lane_q;
        always_ff @(posedge clk) begin
            if (ce && wr_en && be[b]) lane_ram[addr] <= wdata[b*8 +: 8];
            if (ce && rd_en) lane_q <= lane_ram[addr];
        end
    end

    assign rdata_q = {g_lane[1].lane_q, g_lane[0].lane_q};
endmodule // dpb_mem

//--- design/dpb_ddr_psram_bus.sv
// device-side transaction logic of the ddr psram bus
`timescale 1ns/1ps
// How it works
// - command bit 47 high means read, low means write
// - command bit 46 low picks the array, high picks registers
// - command bit 45 picks wrapped or linear burst for the data phase
// - array address is taken from bits 21:16; bits 2:0 pick the word
// - strobe low or high during command cycles asks single or double latency
// - after read latency strobe toggles with data, each byte edge-aligned
// - data keeps flowing while select is low and clock toggles
// - wrapped bursts stay inside burst length; linear bursts run across rows
// - linear burst reaching the end of a die wraps within that die
// - register read sends upper byte then lower byte, every word
// - write byte one taken on rising edge, byte two on falling edge
// - device releases strobe after command cycles of a latency write
// - write strobe high masks the byte, low stores it
// - no extra latency once write data has begun
// - hybrid wrap wraps once then runs linear from the next boundary
// - three command cycles; register write data follows at once
// - zero latency write ignores the strobe and stores full words
// - zero latency write keeps zero latency whatever the strobe showed
// - dual die part always uses the doubled latency count
// - register write updates both dies together
module dpb_ddr_psram_bus
    import dpb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic bus_clock_true,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic read_write_strobe_in,
    output logic read_write_strobe_out,
    output logic read_write_strobe_oe
);

    // ************************************************
    // pin sampling
    // ************************************************
    dpb_pins_s pin_raw;
    dpb_pins_s pin_s1_q;
    dpb_pins_s pin_s2_q;
    dpb_pins_s pin_s3_q;

    assign pin_raw = {cs_n, bus_clock_true, read_write_strobe_in, dq_in};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_q <= PINS_IDLE;
            pin_s2_q <= PINS_IDLE;
            pin_s3_q <= PINS_IDLE;
        end else if (clk_en) begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    wire ck_rise = pin_s2_q.ck && !pin_s3_q.ck;
    wire ck_fall = !pin_s2_q.ck && pin_s3_q.ck;
    wire ck_edge = ck_rise || ck_fall;
    wire cs_act = !pin_s2_q.cs_n;

    // ************************************************
    // state and transaction registers
    // ************************************************
    dpb_state_e state_q;
    dpb_state_e state_d;
    logic [2:0] byte_q;
    logic [CA_W-9:0] ca_q;
    logic is_read_q;
    logic reg_space_q;
    logic linear_q;
    logic hybrid_q;
    logic [OFF_W-1:0] mask_q;
    logic [OFF_W-1:0] start_q;
    logic [MEM_AW-1:0] addr_q;
    logic [1:0] reg_sel_q;
    logic die_q;
    logic [4:0] lat_q;
    logic [4:0] lat_target_q;
    logic [7:0] hi_q;
    logic mhi_q;
    logic [15:0] cfg0_q [DIES];
    logic [15:0] cfg1_q [DIES];
    logic [15:0] mem_rdata;
    logic [7:0] dq_out_q;
    logic dq_oe_q;
    logic read_write_strobe_out_q;
    logic read_write_strobe_oe_q;

    // ************************************************
    // command decode
    // ************************************************
    wire [CA_W-1:0] ca_full = {ca_q, pin_s2_q.dq};
    wire ca_dir = ca_full[CA_DIR];
    wire ca_space = ca_full[CA_SPACE];
    wire ca_lin = ca_full[CA_BURST];
    wire ca_done = state_q == ST_CA && ck_edge && byte_q == CA_LAST;
    wire zero_lat = !ca_dir && ca_space;
    wire [3:0] lat_base = cfg0_q[0][CFG_LAT_HI:CFG_LAT_LO];
    wire ca_ind = DUAL_DIE | cfg0_q[0][CFG_FIXED];
    wire [1:0] bl_sel = cfg0_q[0][CFG_BL_HI:CFG_BL_LO];
    wire [OFF_W-1:0] mask_d = (WRAP_MIN << bl_sel) - OFF_ONE;
    wire [4:0] lat_dbl = {lat_base, 1'b0};
    wire [4:0] lat_one = {1'b0, lat_base};
    wire [4:0] lat_target_d = zero_lat ? LAT_NONE : (ca_ind ? lat_dbl : lat_one);
    wire [UCOL_W-1:0] ucol = ca_full[CA_ROW_LO +: UCOL_W];
    wire [LCOL_W-1:0] lcol = ca_full[LCOL_W-1:0];
    wire [MEM_AW-1:0] start_addr = {ucol, lcol};

    // ************************************************
    // state machine
    // ************************************************
    wire start_ok = state_q == ST_IDLE && cs_act && !pin_s2_q.ck;
    wire go_data = state_q == ST_LAT && ck_rise && lat_q == lat_target_q;
    wire d_rise = (state_q == ST_DATA && ck_rise) || go_data;
    wire d_fall = state_q == ST_DATA && ck_fall;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_ok) state_d = ST_CA;
            end
            ST_CA: begin
                if (ca_done) state_d = ST_LAT;
            end
            ST_LAT: begin
                if (go_data) state_d = ST_DATA;
            end
            ST_DATA: begin
                state_d = ST_DATA;
            end
        endcase
        if (!cs_act) state_d = ST_IDLE;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ************************************************
    // command capture
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            byte_q <= '0;
            ca_q <= '0;
        end else if (clk_en) begin
            if (state_q != ST_CA) byte_q <= '0;
            if (state_q == ST_CA && ck_edge) begin
                byte_q <= byte_q + BYTE_STEP;
                ca_q <= ca_full[CA_W-9:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            is_read_q <= 1'b0;
            reg_space_q <= 1'b0;
            reg_sel_q <= '0;
            die_q <= 1'b0;
            mask_q <= '0;
            start_q <= '0;
            hybrid_q <= 1'b0;
            lat_target_q <= LAT_NONE;
        end else if (clk_en && ca_done) begin
            is_read_q <= ca_dir;
            reg_space_q <= ca_space;
            reg_sel_q <= {ca_full[CA_RCFG], ca_full[CA_RIDX]};
            die_q <= ca_full[CA_DIE];
            mask_q <= mask_d;
            start_q <= start_addr[OFF_W-1:0];
            hybrid_q <= cfg0_q[0][CFG_HYB];
            lat_target_q <= lat_target_d;
        end
    end

    // ************************************************
    // latency count
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lat_q <= LAT_NONE;
        end else if (clk_en) begin
            if (ca_done) lat_q <= LAT_NONE;
            else if (state_q == ST_LAT && ck_rise && !go_data) lat_q <= lat_q + LAT_STEP;
        end
    end

    // ************************************************
    // burst address sequencing
    // ************************************************
    wire [OFF_W-1:0] off = addr_q[OFF_W-1:0];
    wire die_bit = addr_q[MEM_AW-1];
    wire [OFF_W-1:0] lin_off = off + OFF_ONE;
    wire [OFF_W-1:0] wrap_off = (off & ~mask_q) | (lin_off & mask_q);
    wire [OFF_W-1:0] hyb_off = (off | mask_q) + OFF_ONE;
    wire hyb_turn = !linear_q && hybrid_q && wrap_off == start_q;
    wire [OFF_W-1:0] next_off = linear_q ? lin_off : (hyb_turn ? hyb_off : wrap_off);
    wire [MEM_AW-1:0] next_addr = {die_bit, next_off};
    wire mem_step = d_fall && !reg_space_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= '0;
            linear_q <= 1'b0;
        end else if (clk_en) begin
            if (ca_done) begin
                addr_q <= start_addr;
                linear_q <= ca_lin;
            end else if (mem_step) begin
                addr_q <= next_addr;
                if (hyb_turn) linear_q <= 1'b1;
            end
        end
    end

    // ************************************************
    // write capture and write buffer
    // ************************************************
    wire wr_data = !is_read_q;
    wire zl_write = d_fall && wr_data && reg_space_q;
    wire mw_push = d_fall && wr_data && !reg_space_q;
    wire [15:0] wr_word = {hi_q, pin_s2_q.dq};
    wire [1:0] wr_be = ~{mhi_q, pin_s2_q.read_write_strobe};
    dpb_wr_req_s push_req;
    dpb_wr_req_s buf_out;
    logic buf_ready;
    logic buf_valid;

    assign push_req = {addr_q, wr_word, wr_be};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_q <= '0;
            mhi_q <= 1'b0;
        end else if (clk_en && d_rise && wr_data) begin
            hi_q <= pin_s2_q.dq;
            mhi_q <= pin_s2_q.read_write_strobe;
        end
    end

    wire mem_rd_en = (ca_done && ca_dir && !ca_space) || (mem_step && is_read_q);
    wire [MEM_AW-1:0] fetch_addr = (state_q == ST_CA) ? start_addr : next_addr;
    wire mem_wr_en = buf_valid && !mem_rd_en;
    wire [MEM_AW-1:0] mem_addr = mem_rd_en ? fetch_addr : buf_out.addr;

    dpb_buf #(
        .WIDTH($bits(dpb_wr_req_s)),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(ref_clk),
        .rst_n(reset_n),
        .ce(clk_en),
        .in_valid(mw_push && buf_ready),
        .in_data(push_req),
        .in_ready(buf_ready),
        .out_valid(buf_valid),
        .out_data(buf_out),
        .out_ready(!mem_rd_en)
    );

    dpb_mem #(
        .AW(MEM_AW),
        .DEPTH(MEM_DEPTH)
    ) u_mem (
        .clk(ref_clk),
        .ce(clk_en),
        .rd_en(mem_rd_en),
        .wr_en(mem_wr_en),
        .addr(mem_addr),
        .wdata(buf_out.data),
        .be(buf_out.be),
        .rdata_q(mem_rdata)
    );

    // ************************************************
    // configuration registers
    // ************************************************
    wire cfg_we = zl_write && reg_sel_q[1];

    for (genvar d = 0; d < DIES; d++) begin : g_die
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                cfg0_q[d] <= CFG0_RESET;
                cfg1_q[d] <= CFG1_RESET;
            end else if (clk_en && cfg_we) begin
                if (!reg_sel_q[0]) cfg0_q[d] <= wr_word;
                if (reg_sel_q[0]) cfg1_q[d] <= wr_word;
            end
        end
    end

    wire [15:0] id0_word = {1'b0, die_q, 1'b0, ID_ROW_CNT, ID_COL_CNT, MFR_CODE};
    wire [15:0] id1_word = {ID1_PAD, DEV_TYPE};
    wire [15:0] cfg0_word = cfg0_q[die_q];
    wire [15:0] cfg1_word = cfg1_q[die_q];
    wire [15:0] id_word = reg_sel_q[0] ? id1_word : id0_word;
    wire [15:0] cf_word = reg_sel_q[0] ? cfg1_word : cfg0_word;
    wire [15:0] reg_word = reg_sel_q[1] ? cf_word : id_word;
    wire [15:0] rd_word = reg_space_q ? reg_word : mem_rdata;

    // ************************************************
    // pin drivers
    // ************************************************
    wire rd_hi = d_rise && is_read_q;
    wire rd_lo = d_fall && is_read_q;
    wire [7:0] dq_out_d = rd_hi ? rd_word[15:8] : (rd_lo ? rd_word[7:0] : dq_out_q);
    wire dq_oe_d = cs_act && (rd_hi || dq_oe_q);
    wire read_write_strobe_hold = rd_hi ? 1'b1 : (rd_lo ? 1'b0 : read_write_strobe_out_q);
    wire read_write_strobe_out_d = start_ok ? ca_ind : (ca_done ? 1'b0 : read_write_strobe_hold);
    wire read_write_strobe_oe_c = ca_done ? ca_dir : read_write_strobe_oe_q;
    wire read_write_strobe_oe_d = cs_act && (start_ok || read_write_strobe_oe_c);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_out_q <= '0;
            dq_oe_q <= 1'b0;
            read_write_strobe_out_q <= 1'b0;
            read_write_strobe_oe_q <= 1'b0;
        end else if (clk_en) begin
            dq_out_q <= dq_out_d;
            dq_oe_q <= dq_oe_d;
            read_write_strobe_out_q <= read_write_strobe_out_d;
            read_write_strobe_oe_q <= read_write_strobe_oe_d;
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;
    assign read_write_strobe_out = read_write_strobe_out_q;
    assign read_write_strobe_oe = read_write_strobe_oe_q;

    // ************************************************
    // checks
    // ************************************************
    a_cs_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!cs_act && clk_en) |=> (!dq_oe_q && !read_write_strobe_oe_q && state_q == ST_IDLE))
        else $error("outputs still driven after deselect");

    a_ca_indicator: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_CA && $past(state_q) == ST_CA) |-> (read_write_strobe_oe_q && read_write_strobe_out_q == ca_ind))
        else $error("latency indication wrong during command cycles");

    a_write_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ca_done && clk_en && !ca_dir && cs_act) |=> !read_write_strobe_oe_q)
        else $error("strobe not released after write command");

    a_read_strobe: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (rd_hi && clk_en && cs_act) |=> (read_write_strobe_out_q && dq_oe_q && dq_out_q == $past(rd_word[15:8])))
        else $error("read strobe and data not launched together");

    a_dir_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ca_done && clk_en) |=> is_read_q == $past(ca_dir))
        else $error("direction bit not taken");

    a_space_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ca_done && clk_en) |=> reg_space_q == $past(ca_space))
        else $error("space bit not taken");

    a_no_relatency: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_DATA && cs_act && clk_en) |=> state_q == ST_DATA)
        else $error("data phase left while selected");

    a_zero_latency: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ca_done && clk_en && zero_lat && cs_act) |=> (lat_target_q == LAT_NONE))
        else $error("register write got latency");

    a_double_lat: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ca_done && clk_en && !zero_lat && ca_ind) |=> lat_target_q == {$past(lat_base), 1'b0})
        else $error("latency not doubled");

    a_die_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (mem_step && clk_en && cs_act) |=> addr_q[MEM_AW-1] == $past(die_bit))
        else $error("burst crossed die boundary");

    a_wrap_stay: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (mem_step && clk_en && !linear_q && !hybrid_q) |=>
        ((addr_q[OFF_W-1:0] & ~mask_q) == ($past(off) & ~mask_q) &&
        (addr_q[OFF_W-1:0] & mask_q) == (($past(off) + OFF_ONE) & mask_q)))
        else $error("wrapped burst left its block");

endmodule // dpb_ddr_psram_bus

//--- verification/dpb_host_model.sv
// host model driving select, bus clock, data and strobe
`timescale 1ns/1ps
module dpb_host_model (
    input wire logic ref_clk,
    output logic cs_n,
    output logic bus_clock_true,
    output logic [7:0] dq_in,
    output logic read_write_strobe_in,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic read_write_strobe_out,
    input wire logic read_write_strobe_oe
);
    logic [7:0] dq_h = 8'h00;
    logic read_write_strobe_h = 1'b0;
    logic drv_dq = 1'b0;
    logic drv_read_write_strobe = 1'b0;
    initial cs_n = 1'b1;
    initial bus_clock_true = 1'b0;
    // wire level: a released line shows the inverse of its last value
    assign dq_in = dq_oe ? dq_out : (drv_dq ? dq_h : ~dq_h);
    assign read_write_strobe_in = read_write_strobe_oe ? read_write_strobe_out : (drv_read_write_strobe ? read_write_strobe_h : ~read_write_strobe_h);
    // data set a cycle ahead of the edge, held three cycles past it
    task automatic toggle(input logic [7:0] b, input logic m);
        dq_h = b;
        read_write_strobe_h = m;
        @(negedge ref_clk);
        bus_clock_true = ~bus_clock_true;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic sel();
        cs_n = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic send_ca(input logic [47:0] ca);
        drv_dq = 1'b1;
        for (int i = 5; i >= 0; i--) begin
            toggle(ca[i*8 +: 8], 1'b0);
        end
        drv_dq = 1'b0;
    endtask
    // select rises only with the clock low
    task automatic close_tx();
        drv_dq = 1'b0;
        drv_read_write_strobe = 1'b0;
        cs_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask
endmodule // dpb_host_model

//--- verification/dpb_ddr_psram_bus_tb.sv
// self-checking bench for the ddr psram bus device logic
`timescale 1ns/1ps
module dpb_ddr_psram_bus_tb;
    import dpb_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic cs_n, bus_clock_true, read_write_strobe_in, dq_oe, read_write_strobe_out, read_write_strobe_oe;
    logic [7:0] dq_in, dq_out;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    dpb_ddr_psram_bus dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .cs_n(cs_n),
        .bus_clock_true(bus_clock_true), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .read_write_strobe_in(read_write_strobe_in), .read_write_strobe_out(read_write_strobe_out), .read_write_strobe_oe(read_write_strobe_oe));
    dpb_host_model h (.ref_clk(ref_clk), .cs_n(cs_n), .bus_clock_true(bus_clock_true),
        .dq_in(dq_in), .read_write_strobe_in(read_write_strobe_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .read_write_strobe_out(read_write_strobe_out), .read_write_strobe_oe(read_write_strobe_oe));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one transaction; writes send w under mask m, reads compare against w
    task automatic xact(input logic [47:0] ca, input int lat, input int n,
        input logic [127:0] w, input logic [15:0] m);
        logic rd;
        rd = ca[47];
        h.sel();
        check("strobe_ca", {read_write_strobe_oe, read_write_strobe_out}, 2'b11);
        h.send_ca(ca);
        check("strobe_ca_end", read_write_strobe_oe, rd);
        h.drv_read_write_strobe = (lat > 0) && !rd;
        for (int i = 0; i < 2 * lat; i++) begin
            h.toggle(8'h00, 1'b0);
            check("latency", dq_oe, 1'b0);
        end
        h.drv_dq = !rd;
        for (int i = 0; i < n; i++) begin
            h.toggle(w[127-16*i -: 8], m[15-2*i]);
            if (rd) begin
                check("rd_hi", {dq_oe, read_write_strobe_out, dq_out}, {2'b11, w[127-16*i -: 8]});
            end
            h.toggle(w[119-16*i -: 8], m[14-2*i]);
            if (rd) begin
                check("rd_lo", {dq_oe, read_write_strobe_out, dq_out}, {2'b10, w[119-16*i -: 8]});
            end
        end
        h.close_tx();
        check("released", {dq_oe, read_write_strobe_oe}, 2'b00);
    endtask
    // zero-latency register write under a high line, read back from the other die
    task automatic t_reg();
        xact(48'h6000_0100_0000, 0, 1, {16'h0030, 112'h0}, 16'h0000);
        xact(48'hC008_0100_0000, 6, 2, {16'h0030, 16'h0030, 96'h0}, 16'h0000);
        xact(48'hC008_0000_0000, 6, 1, {3'h2, ID_ROW_CNT, ID_COL_CNT, MFR_CODE, 112'h0},
            16'h0000);
        xact(48'hC000_0000_0001, 6, 1, {ID1_PAD, DEV_TYPE, 112'h0}, 16'h0000);
    endtask
    // fill, masked write, then a wrapped read that crosses the wrap boundary
    task automatic t_mem();
        xact(48'h2000_0001_0000, 6, 8, {16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h1004,
            16'h1005, 16'h1006, 16'h1007}, 16'h0000);
        xact(48'h2000_0001_0005, 6, 2, {16'h5522, 16'h3344, 96'h0}, 16'h8000);
        xact(48'h8000_0001_0005, 6, 4, {16'h1022, 16'h3344, 16'h1007, 16'h1000,
            64'h0}, 16'h0000);
    endtask
    // linear write past the last word of die 0 lands on word 0 of that die
    task automatic t_die();
        xact(48'h2000_001F_0007, 6, 2, {16'hD0D0, 16'hD1D1, 96'h0}, 16'h0000);
        xact(48'hA000_0000_0000, 6, 1, {16'hD1D1, 112'h0}, 16'h0000);
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        check("oe_reset", {dq_oe, read_write_strobe_oe}, 2'b00);
        t_reg();
        t_mem();
        t_die();
        test_done();
    end
endmodule // dpb_ddr_psram_bus_tb
